// >>> pkg/dsid_cfg.svh
`ifndef DSID_CFG_SVH
`define DSID_CFG_SVH

// Instruction byte layout
`define DSID_OPC_HI 7
`define DSID_OPC_LO 5
`define DSID_SZA_HI 3
`define DSID_SZA_LO 2
`define DSID_SZB_HI 1
`define DSID_SZB_LO 0
`define DSID_SIB_BIT 2
`define DSID_CSA_HI 3
`define DSID_CSA_LO 0

// Instruction codes
`define DSID_OPC_DLOAD 3'h0
`define DSID_OPC_ILOAD 3'h1
`define DSID_OPC_DSTORE 3'h2
`define DSID_OPC_ISTORE 3'h3
`define DSID_OPC_CSLOAD 3'h4
`define DSID_OPC_REPEAT 3'h5
`define DSID_OPC_CSSTORE 3'h6
`define DSID_OPC_KEY 3'h7

// Field codes
`define DSID_SZ_BYTE 2'h0
`define DSID_SZ_WORD 2'h1
`define DSID_PTR_AT 2'h0
`define DSID_PTR_INC 2'h1
`define DSID_PTR_REG 2'h2
`define DSID_PTR_RSVD 2'h3
`define DSID_KEY_64 2'h0
`define DSID_SIB_128 2'h1

// Counts and values
`define DSID_ACK_CHAR 8'h40
`define DSID_KEY_BYTES 5'h08
`define DSID_SIB_BYTES 5'h10
`define DSID_ONE_BYTE 5'h01
`define DSID_TWO_BYTES 5'h02
`define DSID_RPT_RESET 8'h00
`define DSID_W16_RESET 16'h0000
`define DSID_B8_RESET 8'h00
`define DSID_CNT_RESET 5'h00
`define DSID_GT_RESET 8'h00

`endif

// >>> pkg/dsid_pkg.sv
package dsid_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INSTR,
    ST_ADDR,
    ST_DATA,
    ST_BUS,
    ST_TX,
    ST_ERR
  } dsid_state_type;

endpackage : dsid_pkg

// >>> design/dsid_guard.sv
`timescale 1ns/10ps
`include "dsid_cfg.svh"

module dsid_guard (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Control
  input wire logic i_start,
  input wire logic i_bit_tick,
  input wire logic [7:0] i_idle_bits,
  // Status
  output logic o_done
);
  import dsid_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Idle bits counted in link bit periods after each turnaround
  always_comb begin
    cnt_d = cnt_q;
    if (i_start) begin
      cnt_d = i_idle_bits; // R23
    end else if (i_bit_tick && (cnt_q != `DSID_GT_RESET)) begin
      cnt_d = cnt_q - 8'h01; // R23
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= `DSID_GT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_done = (cnt_q == `DSID_GT_RESET) && !i_start;

  a_guard_count: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R23
    (i_start && (i_idle_bits != `DSID_GT_RESET)) |=> !o_done)
    else $error("guard released without idle bits");

endmodule : dsid_guard

// >>> design/dsid_decoder.sv
`timescale 1ns/10ps
`include "dsid_cfg.svh"
// Summary of operation
// R1: Each one-byte instruction follows a sync character that sets the baud rate.
// R2: Direct load takes address bytes, returns data bytes after the guard time.
// R3: Direct load handles address and data up to 16 bits.
// R4: Size code 00 is byte, 01 is word, others reserved.
// R5: Repeated direct load needs a new address each pass; no auto increment.
// R6: Direct store acknowledges the address, then acknowledges the written data.
// R7: Direct store operands are at most 16 bits each.
// R8: Indirect load reads at the pointer, optional post-increment, or reads the pointer.
// R9: Indirect store with pointer code 2 loads the pointer, then acknowledges.
// R10: Pointer code 0 writes at pointer; code 1 also advances it by data size.
// R11: Indirect store data is acknowledged after the bus write succeeds.
// R12: Repeated indirect store takes each data frame after the previous acknowledge.
// R13: Control/status load returns one byte of a 16-byte space after guard.
// R14: Control/status store writes one byte and sends no response.
// R15: Repeat loads a byte count n; next instruction runs n+1 times.
// R16: Repeated passes take operands only; repeat itself cannot be repeated.
// R17: Only a break aborts a running repeat sequence.
// R18: Key entry takes 8 bytes only; 16-byte size is for info readout.
// R19: Info-select bit makes the key instruction send the info block instead.
// R20: No response follows received key bytes.
// R21: Info block bytes go out after the current guard time.
// R22: A break returns to idle from any state, error included.
// R23: Guard idle bit periods precede the first byte after turnaround.
// R24: The host sends the sync character as value 55 hex.
// R25: Reserved size codes cause no bus access and enter the error state.
// R26: Opcode field positions are fixed locally.

module dsid_decoder (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Receive side of the link layer
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_sync,
  input wire logic i_break,
  input wire logic i_bit_tick,
  // Transmit side of the link layer
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  // Configuration
  input wire logic [7:0] i_guard_idle_count,
  // System bus master
  output logic o_bus_req,
  output logic o_bus_we,
  output logic o_bus_word,
  output logic [15:0] o_bus_addr,
  output logic [15:0] o_bus_wdata,
  input wire logic i_bus_done,
  input wire logic i_bus_ok,
  input wire logic [15:0] i_bus_rdata,
  // Control/status space
  output logic [3:0] o_cs_addr,
  output logic o_cs_we,
  output logic [7:0] o_cs_wdata,
  input wire logic [7:0] i_cs_rdata,
  // Key entry and info block
  output logic o_key_valid,
  output logic [7:0] o_key_byte,
  output logic [3:0] o_sib_idx,
  input wire logic [7:0] i_sib_byte,
  // Status
  output dsid_pkg::dsid_state_type o_state,
  output logic [7:0] o_repeat_left
);
  import dsid_pkg::*;

  dsid_state_type state_q, state_d, l_state;
  logic [7:0] op_q, op_d, op_cur, tx_data_q, tx_data_d, rpt_q, rpt_d, tx_byte;
  logic [15:0] addr_q, addr_d, data_q, data_d, ptr_q, ptr_d, bus_addr_q, bus_addr_d;
  logic [4:0] cnt_q, cnt_d, need_q, need_d, l_need;
  logic mid_q, mid_d, tx_ok_q, tx_ok_d, cs_we_q, cs_we_d, key_q, key_d;
  logic finish, tx_fire, guard_done, guard_start, last_rx;
  logic [2:0] opc, l_opc;
  logic [1:0] sza, szb;

  // Byte count of a size field
  function automatic logic [4:0] size_bytes(input logic [1:0] code);
    size_bytes = (code == `DSID_SZ_WORD) ? `DSID_TWO_BYTES : `DSID_ONE_BYTE; // R4
  endfunction : size_bytes

  // Upper half of the size codes is reserved
  function automatic logic size_bad(input logic [1:0] code);
    size_bad = code[1]; // R4
  endfunction : size_bad

  assign opc = op_q[`DSID_OPC_HI:`DSID_OPC_LO]; // R26
  assign sza = op_q[`DSID_SZA_HI:`DSID_SZA_LO];
  assign szb = op_q[`DSID_SZB_HI:`DSID_SZB_LO];
  assign tx_fire = o_tx_valid && i_tx_ready;
  assign last_rx = (cnt_q + `DSID_ONE_BYTE) == need_q;

  // Decode of a fresh instruction byte, or of the held one on a repeat pass
  always_comb begin
    op_cur = (state_q == ST_INSTR) ? i_rx_data : op_q;
    l_opc = op_cur[`DSID_OPC_HI:`DSID_OPC_LO];
    l_state = ST_ERR;
    l_need = `DSID_ONE_BYTE;
    case (l_opc)
      `DSID_OPC_DLOAD, `DSID_OPC_DSTORE: begin
        // Byte or word operands only, so at most 16 bits
        if (!size_bad(op_cur[`DSID_SZA_HI:`DSID_SZA_LO]) && // R3 R7 R25
            !size_bad(op_cur[`DSID_SZB_HI:`DSID_SZB_LO])) begin
          l_state = ST_ADDR; // R2 R5
          l_need = size_bytes(op_cur[`DSID_SZA_HI:`DSID_SZA_LO]);
        end
      end
      `DSID_OPC_ILOAD, `DSID_OPC_ISTORE: begin
        if (size_bad(op_cur[`DSID_SZB_HI:`DSID_SZB_LO])) begin
          l_state = ST_ERR; // R25
        end else if (op_cur[`DSID_SZA_HI:`DSID_SZA_LO] == `DSID_PTR_REG) begin
          l_state = (l_opc == `DSID_OPC_ILOAD) ? ST_TX : ST_ADDR; // R8 R9
          l_need = size_bytes(op_cur[`DSID_SZB_HI:`DSID_SZB_LO]);
        end else if (op_cur[`DSID_SZA_HI:`DSID_SZA_LO] != `DSID_PTR_RSVD) begin
          l_state = (l_opc == `DSID_OPC_ILOAD) ? ST_BUS : ST_DATA; // R8 R12
          l_need = size_bytes(op_cur[`DSID_SZB_HI:`DSID_SZB_LO]);
        end
      end
      `DSID_OPC_CSLOAD: l_state = ST_TX; // R13
      `DSID_OPC_CSSTORE: l_state = ST_DATA; // R14
      `DSID_OPC_REPEAT: begin
        if (op_cur[`DSID_SZB_HI:`DSID_SZB_LO] == `DSID_SZ_BYTE) begin
          l_state = ST_DATA; // R15
        end
      end
      `DSID_OPC_KEY: begin
        if (op_cur[`DSID_SIB_BIT]) begin
          l_state = ST_TX; // R19
          if (op_cur[`DSID_SZB_HI:`DSID_SZB_LO] == `DSID_KEY_64) begin
            l_need = `DSID_KEY_BYTES;
          end else if (op_cur[`DSID_SZB_HI:`DSID_SZB_LO] == `DSID_SIB_128) begin
            l_need = `DSID_SIB_BYTES; // R18
          end else begin
            l_state = ST_ERR;
          end
        end else if (op_cur[`DSID_SZB_HI:`DSID_SZB_LO] == `DSID_KEY_64) begin
          l_state = ST_DATA; // R18
          l_need = `DSID_KEY_BYTES;
        end
      end
      default: l_state = ST_ERR;
    endcase
  end

  // Byte presented to the link for the current index
  always_comb begin
    tx_byte = data_q[7:0];
    if (opc == `DSID_OPC_DSTORE || opc == `DSID_OPC_ISTORE) begin
      tx_byte = `DSID_ACK_CHAR; // R6 R9 R11
    end else if (opc == `DSID_OPC_CSLOAD) begin
      tx_byte = i_cs_rdata; // R13
    end else if (opc == `DSID_OPC_KEY) begin
      tx_byte = i_sib_byte; // R19
    end else if (opc == `DSID_OPC_ILOAD && sza == `DSID_PTR_REG) begin
      tx_byte = cnt_q[0] ? ptr_q[15:8] : ptr_q[7:0]; // R8
    end else if (cnt_q[0]) begin
      tx_byte = data_q[15:8];
    end
  end

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    ptr_d = ptr_q;
    rpt_d = rpt_q;
    cnt_d = cnt_q + ((state_q == ST_TX && tx_fire) ? `DSID_ONE_BYTE : `DSID_CNT_RESET);
    need_d = need_q;
    mid_d = mid_q;
    bus_addr_d = bus_addr_q;
    cs_we_d = 1'b0;
    key_d = 1'b0;
    finish = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (i_rx_sync) begin
          state_d = ST_INSTR; // R1 R24
        end
      end
      ST_INSTR: begin
        if (i_rx_valid) begin
          op_d = i_rx_data; // R1
          state_d = l_state;
          need_d = l_need;
          bus_addr_d = ptr_q;
        end
      end
      ST_ADDR: begin
        if (i_rx_valid) begin
          cnt_d = cnt_q + `DSID_ONE_BYTE;
          if (cnt_q[0]) begin
            addr_d[15:8] = i_rx_data;
          end else begin
            addr_d = {8'h00, i_rx_data};
          end
          if (last_rx) begin
            bus_addr_d = addr_d;
            need_d = `DSID_ONE_BYTE;
            if (opc == `DSID_OPC_ISTORE) begin
              ptr_d = addr_d; // R9
              state_d = ST_TX;
            end else if (opc == `DSID_OPC_DSTORE) begin
              mid_d = 1'b1; // R6
              state_d = ST_TX;
            end else begin
              state_d = ST_BUS; // R2
            end
          end
        end
      end
      ST_DATA: begin
        if (i_rx_valid) begin
          cnt_d = cnt_q + `DSID_ONE_BYTE;
          if (cnt_q[0] && opc != `DSID_OPC_KEY) begin
            data_d[15:8] = i_rx_data;
          end else begin
            data_d = {8'h00, i_rx_data};
          end
          key_d = (opc == `DSID_OPC_KEY);
          if (last_rx) begin
            case (opc)
              `DSID_OPC_REPEAT: begin
                rpt_d = i_rx_data; // R15 R16
                state_d = ST_IDLE;
              end
              `DSID_OPC_CSSTORE: begin
                cs_we_d = 1'b1; // R14
                finish = 1'b1;
              end
              `DSID_OPC_KEY: finish = 1'b1; // R20
              default: state_d = ST_BUS; // R11
            endcase
          end
        end
      end
      ST_BUS: begin
        if (i_bus_done) begin
          if (!i_bus_ok) begin
            state_d = ST_ERR;
          end else begin
            state_d = ST_TX;
            if (o_bus_we) begin
              need_d = `DSID_ONE_BYTE; // R11
            end else begin
              data_d = i_bus_rdata; // R2 R8
              need_d = size_bytes(szb);
            end
            if (opc[0] && sza == `DSID_PTR_INC) begin
              ptr_d = ptr_q + 16'(size_bytes(szb)); // R10
            end
          end
        end
      end
      ST_TX: begin
        if (tx_fire && cnt_d == need_q) begin
          if (mid_q) begin
            mid_d = 1'b0;
            state_d = ST_DATA; // R6
            need_d = size_bytes(szb);
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_ERR: state_d = ST_ERR; // R25
      default: state_d = ST_ERR;
    endcase
    // Repeat passes reuse the held instruction without sync or opcode
    if (finish) begin
      cnt_d = `DSID_CNT_RESET;
      state_d = ST_IDLE;
      if (rpt_q != `DSID_RPT_RESET) begin
        rpt_d = rpt_q - 8'h01; // R15 R16
        state_d = l_state; // R5 R12
        need_d = l_need;
        bus_addr_d = ptr_d;
      end
    end
    if (state_d != state_q) begin
      cnt_d = `DSID_CNT_RESET;
    end
    if (i_break) begin
      state_d = ST_IDLE; // R17 R22
      rpt_d = `DSID_RPT_RESET;
      mid_d = 1'b0;
    end
    tx_ok_d = (state_q == ST_TX) && (state_d == ST_TX) && !tx_fire;
    tx_data_d = tx_byte;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      op_q <= `DSID_B8_RESET;
      addr_q <= `DSID_W16_RESET;
      data_q <= `DSID_W16_RESET;
      ptr_q <= `DSID_W16_RESET;
      bus_addr_q <= `DSID_W16_RESET;
      rpt_q <= `DSID_RPT_RESET;
      cnt_q <= `DSID_CNT_RESET;
      need_q <= `DSID_ONE_BYTE;
      mid_q <= 1'b0;
      tx_ok_q <= 1'b0;
      tx_data_q <= `DSID_B8_RESET;
      cs_we_q <= 1'b0;
      key_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      ptr_q <= ptr_d;
      bus_addr_q <= bus_addr_d;
      rpt_q <= rpt_d;
      cnt_q <= cnt_d;
      need_q <= need_d;
      mid_q <= mid_d;
      tx_ok_q <= tx_ok_d;
      tx_data_q <= tx_data_d;
      cs_we_q <= cs_we_d;
      key_q <= key_d;
    end
  end

  // Guard restarts on every receive-to-transmit turnaround
  assign guard_start = (state_d == ST_TX) && (state_q != ST_TX) && !i_break;

  dsid_guard u_guard (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_start(guard_start),
    .i_bit_tick(i_bit_tick),
    .i_idle_bits(i_guard_idle_count),
    .o_done(guard_done)
  );

  assign o_tx_valid = (state_q == ST_TX) && tx_ok_q && guard_done; // R21 R23
  assign o_tx_data = tx_data_q;
  assign o_bus_req = (state_q == ST_BUS);
  assign o_bus_we = opc[1];
  assign o_bus_word = (szb == `DSID_SZ_WORD);
  assign o_bus_addr = bus_addr_q;
  assign o_bus_wdata = data_q;
  assign o_cs_addr = op_q[`DSID_CSA_HI:`DSID_CSA_LO]; // R13 R14
  assign o_cs_we = cs_we_q;
  assign o_cs_wdata = data_q[7:0];
  assign o_key_valid = key_q;
  assign o_key_byte = data_q[7:0];
  assign o_sib_idx = cnt_q[3:0];
  assign o_state = state_q;
  assign o_repeat_left = rpt_q;

  default clocking dsid_cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_instr_in;
    (state_q == ST_INSTR) && i_rx_valid;
  endsequence
  sequence s_write_done;
    (state_q == ST_BUS) && i_bus_done && i_bus_ok && o_bus_we;
  endsequence
  sequence s_ptr_last;
    (state_q == ST_ADDR) && i_rx_valid && last_rx && (opc == `DSID_OPC_ISTORE) && !i_break;
  endsequence

  a_break_to_idle: assert property (i_break |=> state_q == ST_IDLE) // R22
    else $error("break did not return to idle");
  a_reserved_size: assert property (s_instr_in ##0 (!i_break && // R25
    (i_rx_data[`DSID_SZA_HI] || i_rx_data[`DSID_SZB_HI]) &&
    i_rx_data[`DSID_OPC_HI:`DSID_OPC_LO] == `DSID_OPC_DLOAD) |=> state_q == ST_ERR)
    else $error("reserved size not trapped");
  a_write_ack: assert property (s_write_done ##0 !i_break |=> state_q == ST_TX ##1 // R6
    o_tx_data == `DSID_ACK_CHAR)
    else $error("bus write not acknowledged");
  a_ptr_load: assert property (s_ptr_last |=> (ptr_q == addr_q) && state_q == ST_TX) // R9
    else $error("pointer load wrong");
  a_ptr_advance: assert property (s_write_done ##0 (opc == `DSID_OPC_ISTORE && // R10
    sza == `DSID_PTR_INC) |=> ptr_q == $past(ptr_q) + 16'(size_bytes(szb)))
    else $error("pointer not advanced by size");
  a_repeat_count: assert property ((state_q == ST_DATA) && i_rx_valid && !i_break && // R15
    opc == `DSID_OPC_REPEAT |=> rpt_q == $past(i_rx_data))
    else $error("repeat count not loaded");
  a_cs_silent: assert property (o_cs_we |-> !o_tx_valid && state_q != ST_TX) // R14
    else $error("response after control store");
  a_key_silent: assert property (o_key_valid |-> !o_tx_valid) // R20
    else $error("response during key entry");
  a_guard_first: assert property ($rose(state_q == ST_TX) && // R23
    $past(i_guard_idle_count) != `DSID_GT_RESET |-> !o_tx_valid [*2])
    else $error("byte sent before guard time");

endmodule : dsid_decoder

// >>> bench/dsid_host_model.sv
`timescale 1ns/10ps

module dsid_host_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Link side
  input wire logic i_tx_valid,
  input wire logic i_slow,
  output logic o_tx_ready,
  // Bus side
  input wire logic i_bus_req,
  input wire logic [15:0] i_bus_addr,
  output logic o_bus_done,
  output logic o_bus_ok,
  output logic [15:0] o_bus_rdata
);
  logic [2:0] wait_q;

  initial begin
    o_tx_ready = 1'b0;
    o_bus_done = 1'b0;
    o_bus_ok = 1'b0;
    o_bus_rdata = 16'h0000;
    wait_q = 3'h0;
  end

  // Slow mode stalls both the byte sink and the bus
  always @(posedge i_clk_sys) begin
    #1;
    o_tx_ready = i_slow ? (i_tx_valid && !o_tx_ready) : 1'b1;
    if (i_rst_b && i_bus_req && !o_bus_done && wait_q == (i_slow ? 3'h3 : 3'h0)) begin
      o_bus_done = 1'b1;
      o_bus_ok = 1'b1;
      o_bus_rdata = i_bus_addr ^ 16'h5A5A;
      wait_q = 3'h0;
    end else begin
      o_bus_done = 1'b0;
      o_bus_ok = 1'b0;
      // Idle read data keeps changing so stale values never match
      o_bus_rdata = ~o_bus_rdata;
      wait_q = i_bus_req ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule : dsid_host_model

// >>> bench/dsid_decoder_bench.sv
`timescale 1ns/10ps
`include "dsid_cfg.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module dsid_decoder_bench;
  import dsid_pkg::*;
  logic i_clk_sys, i_rst_b, i_rx_valid, i_rx_sync, i_break, i_bit_tick, i_slow;
  logic [7:0] i_rx_data, o_tx_data, o_cs_wdata, o_key_byte, o_repeat_left, b, last_key;
  logic o_tx_valid, i_tx_ready, o_bus_req, o_bus_we, o_bus_word, i_bus_done, i_bus_ok;
  logic o_cs_we, o_key_valid;
  logic [15:0] o_bus_addr, o_bus_wdata, i_bus_rdata;
  logic [3:0] o_cs_addr, o_sib_idx, tick_cnt;
  logic [7:0] i_guard_idle_count;
  logic [11:0] last_cs;
  logic [33:0] r;
  dsid_state_type o_state;
  logic [7:0] txq[$];
  logic [33:0] busq[$];
  int mismatches, check_count, key_cnt, cs_cnt;
  wire [7:0] i_cs_rdata = {4'hC, o_cs_addr};
  wire [7:0] i_sib_byte = {o_sib_idx, ~o_sib_idx};

  dsid_decoder u_dsid_decoder (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_sync(i_rx_sync),
    .i_break(i_break), .i_bit_tick(i_bit_tick), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .i_guard_idle_count(i_guard_idle_count),
    .o_bus_req(o_bus_req), .o_bus_we(o_bus_we), .o_bus_word(o_bus_word),
    .o_bus_addr(o_bus_addr), .o_bus_wdata(o_bus_wdata), .i_bus_done(i_bus_done),
    .i_bus_ok(i_bus_ok), .i_bus_rdata(i_bus_rdata), .o_cs_addr(o_cs_addr),
    .o_cs_we(o_cs_we), .o_cs_wdata(o_cs_wdata), .i_cs_rdata(i_cs_rdata),
    .o_key_valid(o_key_valid), .o_key_byte(o_key_byte), .o_sib_idx(o_sib_idx),
    .i_sib_byte(i_sib_byte), .o_state(o_state), .o_repeat_left(o_repeat_left));

  dsid_host_model u_dsid_host_model (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_tx_valid(o_tx_valid), .i_slow(i_slow), .o_tx_ready(i_tx_ready),
    .i_bus_req(o_bus_req), .i_bus_addr(o_bus_addr), .o_bus_done(i_bus_done),
    .o_bus_ok(i_bus_ok), .o_bus_rdata(i_bus_rdata));

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) begin
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) txq.push_back(o_tx_data);
    if (o_bus_req === 1'b1 && i_bus_done === 1'b1)
      busq.push_back({o_bus_we, o_bus_word, o_bus_addr, o_bus_wdata});
    if (o_key_valid === 1'b1) begin
      key_cnt++;
      last_key = o_key_byte;
    end
    if (o_cs_we === 1'b1) begin
      cs_cnt++;
      last_cs = {o_cs_addr, o_cs_wdata};
    end
    #1;
    tick_cnt = tick_cnt + 4'h1;
    i_bit_tick = (tick_cnt[1:0] == 2'h3);
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : step

  task automatic send(input logic [7:0] v);
    step(1);
    i_rx_valid = 1'b1;
    i_rx_data = v;
    step(1);
    i_rx_valid = 1'b0;
    i_rx_data = ~v;
  endtask : send

  task automatic wait_idle;
    int n;
    n = 0;
    while (o_state !== ST_IDLE && n < 400) begin
      step(1);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_idle

  task automatic instr(input logic [7:0] op);
    wait_idle();
    i_rx_sync = 1'b1;
    step(1);
    i_rx_sync = 1'b0;
    send(op);
  endtask : instr

  task automatic next_tx;
    int n;
    n = 0;
    while (txq.size() == 0 && n < 400) begin
      step(1);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      complete_run();
    end
    b = txq.pop_front();
  endtask : next_tx

  task automatic t_direct_load;
    instr({`DSID_OPC_DLOAD, 1'b0, `DSID_SZ_WORD, `DSID_SZ_WORD});
    send(8'h34);
    send(8'h12);
    next_tx();
    `CHK(b, 8'h6E)
    next_tx();
    `CHK(b, 8'h48)
    r = busq.pop_front();
    `CHK(r[33:16], {2'b01, 16'h1234})
    $display("done direct_load");
  endtask : t_direct_load

  task automatic t_repeat_load;
    i_slow = 1'b1;
    instr({`DSID_OPC_REPEAT, 5'h00});
    send(8'h01);
    instr({`DSID_OPC_DLOAD, 1'b0, `DSID_SZ_BYTE, `DSID_SZ_BYTE});
    for (int k = 0; k < 2; k++) begin
      send(8'h10);
      next_tx();
      `CHK(b, 8'h4A)
      r = busq.pop_front();
      `CHK(r[33:16], {2'b00, 16'h0010})
    end
    step(4);
    `CHK(busq.size(), 0)
    `CHK(o_repeat_left, 8'h00)
    i_slow = 1'b0;
    $display("done repeat_load");
  endtask : t_repeat_load

  task automatic t_direct_store;
    instr({`DSID_OPC_DSTORE, 1'b0, `DSID_SZ_BYTE, `DSID_SZ_BYTE});
    send(8'h80);
    next_tx();
    `CHK(b, `DSID_ACK_CHAR)
    send(8'h99);
    next_tx();
    `CHK(b, `DSID_ACK_CHAR)
    r = busq.pop_front();
    `CHK({r[33:16], r[7:0]}, {2'b10, 16'h0080, 8'h99})
    $display("done direct_store");
  endtask : t_direct_store

  task automatic t_indirect;
    instr({`DSID_OPC_ISTORE, 1'b0, `DSID_PTR_REG, `DSID_SZ_WORD});
    send(8'h00);
    send(8'h20);
    next_tx();
    `CHK(b, `DSID_ACK_CHAR)
    instr({`DSID_OPC_REPEAT, 5'h00});
    send(8'h01);
    instr({`DSID_OPC_ISTORE, 1'b0, `DSID_PTR_INC, `DSID_SZ_BYTE});
    for (int k = 0; k < 2; k++) begin
      send(8'h11 + 8'(k));
      next_tx();
      `CHK(b, `DSID_ACK_CHAR)
      r = busq.pop_front();
      `CHK({r[33:16], r[7:0]}, {2'b10, 16'h2000 + 16'(k), 8'h11 + 8'(k)})
    end
    instr({`DSID_OPC_ILOAD, 1'b0, `DSID_PTR_REG, `DSID_SZ_WORD});
    next_tx();
    `CHK(b, 8'h02)
    next_tx();
    `CHK(b, 8'h20)
    instr({`DSID_OPC_ILOAD, 1'b0, `DSID_PTR_AT, `DSID_SZ_BYTE});
    next_tx();
    `CHK(b, 8'h58)
    r = busq.pop_front();
    `CHK(r[33:16], {2'b00, 16'h2002})
    $display("done indirect");
  endtask : t_indirect

  task automatic t_cs_space;
    i_guard_idle_count = 8'h00;
    instr({`DSID_OPC_CSSTORE, 1'b0, 4'h3});
    send(8'h7E);
    step(3);
    `CHK(last_cs, {4'h3, 8'h7E})
    `CHK(cs_cnt, 1)
    `CHK(txq.size(), 0)
    instr({`DSID_OPC_CSLOAD, 1'b0, 4'h5});
    next_tx();
    `CHK(b, 8'hC5)
    i_guard_idle_count = 8'h02;
    $display("done cs_space");
  endtask : t_cs_space

  task automatic t_key;
    instr({`DSID_OPC_KEY, 1'b0, 1'b0, 1'b0, `DSID_KEY_64});
    for (int k = 0; k < 8; k++) send(8'h30 + 8'(k));
    step(3);
    `CHK(key_cnt, 8)
    `CHK(last_key, 8'h37)
    `CHK(txq.size(), 0)
    instr({`DSID_OPC_KEY, 1'b0, 1'b0, 1'b1, `DSID_SIB_128});
    for (int k = 0; k < 16; k++) begin
      next_tx();
      `CHK(b, {4'(k), ~4'(k)})
    end
    $display("done key");
  endtask : t_key

  task automatic t_error_abort;
    instr({`DSID_OPC_DLOAD, 1'b0, 2'h2, `DSID_SZ_BYTE});
    step(2);
    `CHK(o_state, ST_ERR)
    send(8'h01);
    step(4);
    `CHK(busq.size(), 0)
    i_break = 1'b1;
    step(1);
    i_break = 1'b0;
    step(2);
    `CHK(o_state, ST_IDLE)
    instr({`DSID_OPC_REPEAT, 5'h00});
    send(8'h05);
    instr({`DSID_OPC_DLOAD, 1'b0, `DSID_SZ_BYTE, `DSID_SZ_BYTE});
    send(8'h10);
    next_tx();
    `CHK(b, 8'h4A)
    r = busq.pop_front();
    i_break = 1'b1;
    step(1);
    i_break = 1'b0;
    step(2);
    `CHK(o_state, ST_IDLE)
    `CHK(o_repeat_left, 8'h00)
    $display("done error_abort");
  endtask : t_error_abort

  initial begin
    i_rst_b = 1'b0;
    i_rx_valid = 1'b0;
    i_rx_data = 8'h00;
    i_rx_sync = 1'b0;
    i_break = 1'b0;
    i_bit_tick = 1'b0;
    i_slow = 1'b0;
    tick_cnt = 4'h0;
    i_guard_idle_count = 8'h02;
    mismatches = 0;
    check_count = 0;
    key_cnt = 0;
    cs_cnt = 0;
    step(8);
    i_rst_b = 1'b1;
    `CHK(o_state, ST_IDLE)
    t_direct_load();
    t_repeat_load();
    t_direct_store();
    t_indirect();
    t_cs_space();
    t_key();
    t_error_abort();
    complete_run();
  end
endmodule : dsid_decoder_bench
